// ---- logic/jtag_tap_device.sv ----
// test access port end: controller, instruction and data registers
`timescale 1ns/10ps
module jtag_tap_device (
   // system clock and power-on reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // fuses and software control
   input wire logic i_port_enable_fuse,
   input wire logic i_software_port_disable_bit,
   input wire logic i_debug_enable_fuse,
   // parallel capture values
   input wire logic [jtag_tap_pkg::BSCAN_LEN-1:0] i_bscan_capture,
   input wire logic [jtag_tap_pkg::PROG_LEN-1:0] i_prog_capture,
   input wire logic [jtag_tap_pkg::ISCAN_LEN-1:0] i_iscan_capture,
   input wire logic [jtag_tap_pkg::BRK_LEN-1:0] i_brk_capture,
   // latched parallel outputs
   output logic [jtag_tap_pkg::BSCAN_LEN-1:0] o_bscan_q,
   output logic [jtag_tap_pkg::PROG_LEN-1:0] o_prog_q,
   output logic [jtag_tap_pkg::ISCAN_LEN-1:0] o_iscan_q,
   output logic [jtag_tap_pkg::BRK_LEN-1:0] o_brk_q,
   // controller status
   output logic [jtag_tap_pkg::IR_LEN-1:0] o_instruction,
   output logic o_run_idle,
   output logic o_gpio_mode,
   // port pins
   jtag_tap_if.device tap
);
   // synchronisers for the pins; tck_s3 is only for edge finding
   logic tck_s1, tck_s2, tck_s3;
   logic tms_s1, tms_s2;
   logic tdi_s1, tdi_s2;
   logic tck_rise; // one cycle per rising tck
   logic tck_fall; // one cycle per falling tck
   logic enabled; // port in use
   // controller and registers
   jtag_tap_pkg::tap_state_t state_q, state_d;
   logic [jtag_tap_pkg::IR_LEN-1:0] ir_sh_q, ir_sh_d; // instruction shifter
   logic [jtag_tap_pkg::IR_LEN-1:0] ir_q, ir_d; // latched instruction
   logic [jtag_tap_pkg::DR_MAX-1:0] dr_q, dr_d; // shared data shifter
   logic [jtag_tap_pkg::DR_MAX-1:0] cap_val; // value loaded in capture-dr
   logic [jtag_tap_pkg::LEN_W-1:0] dr_len; // length of selected register
   logic [jtag_tap_pkg::BSCAN_LEN-1:0] bscan_d;
   logic [jtag_tap_pkg::PROG_LEN-1:0] prog_d;
   logic [jtag_tap_pkg::ISCAN_LEN-1:0] iscan_d;
   logic [jtag_tap_pkg::BRK_LEN-1:0] brk_d;
   logic tdo_q, tdo_d, oe_q, oe_d;
   logic is_shift_dr, is_shift_ir;

   // both port enables are needed; no test reset pin exists
   assign enabled = i_port_enable_fuse && !i_software_port_disable_bit;
   assign o_gpio_mode = !enabled;
   assign tap.pullup_en = enabled;
   assign tck_rise = tck_s2 && !tck_s3;
   assign tck_fall = !tck_s2 && tck_s3;
   assign is_shift_dr = (state_q == jtag_tap_pkg::ST_SHIFT_DR);
   assign is_shift_ir = (state_q == jtag_tap_pkg::ST_SHIFT_IR);
   assign o_instruction = ir_q;
   assign o_run_idle = (state_q == jtag_tap_pkg::ST_IDLE);
   assign tap.tdo = tdo_q;
   assign tap.tdo_oe = oe_q;

   // two flip-flops on every pin before any logic reads it
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_s3 <= 1'b0;
         tms_s1 <= 1'b1;
         tms_s2 <= 1'b1;
         tdi_s1 <= 1'b1;
         tdi_s2 <= 1'b1;
      end else begin
         tck_s1 <= tap.tck;
         tck_s2 <= tck_s1;
         tck_s3 <= tck_s2;
         tms_s1 <= tap.tms;
         tms_s2 <= tms_s1;
         tdi_s1 <= tap.tdi;
         tdi_s2 <= tdi_s1;
      end
   end

   // selected data register length; debug chains need the debug fuse
   always_comb begin
      dr_len = 6'h01;
      cap_val = '0;
      case (ir_q)
         jtag_tap_pkg::INS_IDCODE: begin
            dr_len = 6'h20;
            cap_val = jtag_tap_pkg::ID_VALUE;
         end
         jtag_tap_pkg::INS_EXTEST, jtag_tap_pkg::INS_SAMPLE: begin
            dr_len = 6'h08;
            cap_val[jtag_tap_pkg::BSCAN_LEN-1:0] = i_bscan_capture;
         end
         jtag_tap_pkg::INS_PROG: begin
            dr_len = 6'h10;
            cap_val[jtag_tap_pkg::PROG_LEN-1:0] = i_prog_capture;
         end
         jtag_tap_pkg::INS_DBG_ISCAN: begin
            if (i_debug_enable_fuse) begin
               dr_len = 6'h08;
               cap_val[jtag_tap_pkg::ISCAN_LEN-1:0] = i_iscan_capture;
            end
         end
         jtag_tap_pkg::INS_DBG_BRK: begin
            if (i_debug_enable_fuse) begin
               dr_len = 6'h08;
               cap_val[jtag_tap_pkg::BRK_LEN-1:0] = i_brk_capture;
            end
         end
         default: begin
            dr_len = 6'h01; // bypass: one bit, captures zero
         end
      endcase
   end

   // controller next state, taken at a rising tck; a disabled port goes to reset at once
   always_comb begin
      state_d = state_q;
      if (!enabled) begin
         state_d = jtag_tap_pkg::ST_RESET;
      end else if (tck_rise) begin
         case (state_q)
            jtag_tap_pkg::ST_RESET:
               state_d = tms_s2 ? jtag_tap_pkg::ST_RESET : jtag_tap_pkg::ST_IDLE;
            jtag_tap_pkg::ST_IDLE:
               state_d = tms_s2 ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_IDLE;
            jtag_tap_pkg::ST_SEL_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_SEL_IR : jtag_tap_pkg::ST_CAP_DR;
            jtag_tap_pkg::ST_CAP_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_EXIT1_DR : jtag_tap_pkg::ST_SHIFT_DR;
            jtag_tap_pkg::ST_SHIFT_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_EXIT1_DR : jtag_tap_pkg::ST_SHIFT_DR;
            jtag_tap_pkg::ST_EXIT1_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_UPD_DR : jtag_tap_pkg::ST_PAUSE_DR;
            jtag_tap_pkg::ST_PAUSE_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_EXIT2_DR : jtag_tap_pkg::ST_PAUSE_DR;
            jtag_tap_pkg::ST_EXIT2_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_UPD_DR : jtag_tap_pkg::ST_SHIFT_DR;
            jtag_tap_pkg::ST_UPD_DR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_IDLE;
            jtag_tap_pkg::ST_SEL_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_RESET : jtag_tap_pkg::ST_CAP_IR;
            jtag_tap_pkg::ST_CAP_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_EXIT1_IR : jtag_tap_pkg::ST_SHIFT_IR;
            jtag_tap_pkg::ST_SHIFT_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_EXIT1_IR : jtag_tap_pkg::ST_SHIFT_IR;
            jtag_tap_pkg::ST_EXIT1_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_UPD_IR : jtag_tap_pkg::ST_PAUSE_IR;
            jtag_tap_pkg::ST_PAUSE_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_EXIT2_IR : jtag_tap_pkg::ST_PAUSE_IR;
            jtag_tap_pkg::ST_EXIT2_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_UPD_IR : jtag_tap_pkg::ST_SHIFT_IR;
            jtag_tap_pkg::ST_UPD_IR:
               state_d = tms_s2 ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_IDLE;
            default: state_d = jtag_tap_pkg::ST_RESET;
         endcase
      end
   end

   // capture and shift at rising tck; exit and pause states leave all alone
   always_comb begin
      ir_sh_d = ir_sh_q;
      dr_d = dr_q;
      if (enabled && tck_rise) begin
         if (state_q == jtag_tap_pkg::ST_CAP_IR) begin
            ir_sh_d = jtag_tap_pkg::IR_CAPTURE;
         end else if (is_shift_ir) begin
            ir_sh_d = {tdi_s2, ir_sh_q[jtag_tap_pkg::IR_LEN-1:1]};
         end else if (state_q == jtag_tap_pkg::ST_CAP_DR) begin
            dr_d = cap_val;
         end else if (is_shift_dr) begin
            // new bit enters at the top of the selected length
            for (int i = 0; i < jtag_tap_pkg::DR_MAX; i++) begin
               if (i == int'(dr_len) - 1) begin
                  dr_d[i] = tdi_s2;
               end else if (i < int'(dr_len) - 1) begin
                  dr_d[i] = dr_q[i+1];
               end else begin
                  dr_d[i] = 1'b0;
               end
            end
         end
      end
   end

   // latching at falling tck while in an update state
   always_comb begin
      ir_d = ir_q;
      bscan_d = o_bscan_q;
      prog_d = o_prog_q;
      iscan_d = o_iscan_q;
      brk_d = o_brk_q;
      if (state_q == jtag_tap_pkg::ST_RESET) begin
         ir_d = jtag_tap_pkg::IR_RESET;
      end else if (tck_fall && state_q == jtag_tap_pkg::ST_UPD_IR) begin
         ir_d = ir_sh_q;
      end else if (tck_fall && state_q == jtag_tap_pkg::ST_UPD_DR) begin
         if (ir_q == jtag_tap_pkg::INS_EXTEST || ir_q == jtag_tap_pkg::INS_SAMPLE) begin
            bscan_d = dr_q[jtag_tap_pkg::BSCAN_LEN-1:0];
         end else if (ir_q == jtag_tap_pkg::INS_PROG) begin
            prog_d = dr_q[jtag_tap_pkg::PROG_LEN-1:0];
         end else if (ir_q == jtag_tap_pkg::INS_DBG_ISCAN && i_debug_enable_fuse) begin
            iscan_d = dr_q[jtag_tap_pkg::ISCAN_LEN-1:0];
         end else if (ir_q == jtag_tap_pkg::INS_DBG_BRK && i_debug_enable_fuse) begin
            brk_d = dr_q[jtag_tap_pkg::BRK_LEN-1:0];
         end
      end
   end

   // tdo moves at falling tck so the far end samples a settled bit
   always_comb begin
      tdo_d = tdo_q;
      oe_d = oe_q;
      if (!enabled) begin
         oe_d = 1'b0;
      end else if (tck_fall) begin
         oe_d = is_shift_ir || is_shift_dr;
         tdo_d = is_shift_ir ? ir_sh_q[0] : dr_q[0];
      end
   end

   // register every group
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= jtag_tap_pkg::ST_RESET;
         ir_sh_q <= jtag_tap_pkg::IR_CAPTURE;
         ir_q <= jtag_tap_pkg::IR_RESET;
         dr_q <= '0;
         o_bscan_q <= '0;
         o_prog_q <= '0;
         o_iscan_q <= '0;
         o_brk_q <= '0;
         tdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
         dr_q <= dr_d;
         o_bscan_q <= bscan_d;
         o_prog_q <= prog_d;
         o_iscan_q <= iscan_d;
         o_brk_q <= brk_d;
         tdo_q <= tdo_d;
         oe_q <= oe_d;
      end
   end
endmodule // jtag_tap_device

// ---- logic/jtag_tap_pkg.sv ----
// shared constants and types for the test access port and its controller
package jtag_tap_pkg;
   // controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
      ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } tap_state_t;
   // register lengths
   localparam int IR_LEN = 4;
   localparam int DR_MAX = 32;
   localparam int ID_LEN = 32;
   localparam int BSCAN_LEN = 8;
   localparam int PROG_LEN = 16;
   localparam int ISCAN_LEN = 8;
   localparam int BRK_LEN = 8;
   localparam int LEN_W = 6;
   // captured instruction value and value after reset
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
   // instruction codes
   localparam logic [IR_LEN-1:0] INS_EXTEST = 4'h0;
   localparam logic [IR_LEN-1:0] INS_IDCODE = 4'h1;
   localparam logic [IR_LEN-1:0] INS_SAMPLE = 4'h2;
   localparam logic [IR_LEN-1:0] INS_PROG = 4'h4;
   localparam logic [IR_LEN-1:0] INS_DBG_ISCAN = 4'h8;
   localparam logic [IR_LEN-1:0] INS_DBG_BRK = 4'h9;
   localparam logic [IR_LEN-1:0] INS_BYPASS = 4'hf;
   localparam logic [IR_LEN-1:0] IR_RESET = INS_IDCODE;
   // identification word, value is arbitrary (bit 0 set)
   localparam logic [ID_LEN-1:0] ID_VALUE = 32'h0a5c_3001;
   // timing: link clock made by the controller end
   localparam int CLK_PERIOD_NS = 25;
   localparam int TCK_PERIOD_NS = 200;
   localparam int TCK_HALF_CYC = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int TCK_DIV_W = 4;
   // navigation sequences, tms bits sent first at bit 0
   localparam int RESET_ONES = 5;
   localparam logic [5:0] SEQ_RESET = 6'h1f;
   localparam logic [5:0] SEQ_TO_SHIFT_IR = 6'h03;
   localparam logic [5:0] SEQ_TO_SHIFT_DR = 6'h01;
   localparam logic [2:0] LEN_RESET = 3'h6;
   localparam logic [2:0] LEN_TO_IR = 3'h4;
   localparam logic [2:0] LEN_TO_DR = 3'h3;
endpackage

// ---- logic/jtag_tap_if.sv ----
// pins between test access port and external test controller
`timescale 1ns/10ps
interface jtag_tap_if;
   logic tck; // link clock, made by the controller
   logic tms; // mode select
   logic tdi; // data into the port
   logic tdo; // data out value from the port
   logic tdo_oe; // port drives tdo
   logic pullup_en; // port pulls its pins high
   logic srst_oe; // controller pulls system reset low
   logic srst_ext_oe; // any other open-collector reset source
   logic tdo_pin; // resolved tdo level
   logic srst_n; // resolved system reset line, pulled up
   // undriven tdo floats high through a pull-up
   assign tdo_pin = tdo_oe ? tdo : 1'b1;
   // open-collector wired-and reset line
   assign srst_n = !(srst_oe || srst_ext_oe);
   modport device (input tck, input tms, input tdi, output tdo, output tdo_oe,
      output pullup_en);
   modport host (output tck, output tms, output tdi, input tdo_pin, output srst_oe,
      input srst_n);
endinterface

// ---- logic/jtag_tap_host.sv ----
// external test controller end: makes tck and drives scan sequences
`timescale 1ns/10ps
module jtag_tap_host (
   // system clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // scan command
   input wire logic i_start,
   input wire logic i_reset_tap,
   input wire logic i_is_ir,
   input wire logic [jtag_tap_pkg::LEN_W-1:0] i_len,
   input wire logic [jtag_tap_pkg::DR_MAX-1:0] i_data,
   // scan answer
   output logic o_busy,
   output logic o_done,
   output logic [jtag_tap_pkg::DR_MAX-1:0] o_rdata,
   // system reset control and view
   input wire logic i_sys_reset,
   output logic o_sys_reset_seen,
   // port pins
   jtag_tap_if.host tap
);
   typedef enum logic [1:0] {H_IDLE, H_PRE, H_SHIFT, H_POST} host_state_t;
   host_state_t st_q, st_d;
   logic [jtag_tap_pkg::TCK_DIV_W-1:0] div_q, div_d; // half-period counter
   logic tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
   logic [jtag_tap_pkg::LEN_W-1:0] cnt_q, cnt_d; // bit slot in phase
   logic [5:0] seq_q, seq_d; // navigation tms bits
   logic [2:0] seq_len_q, seq_len_d;
   logic rst_only_q, rst_only_d; // reset sequence with no shift
   logic [jtag_tap_pkg::LEN_W-1:0] len_q, len_d;
   logic [jtag_tap_pkg::DR_MAX-1:0] tx_q, tx_d, rx_q, rx_d;
   logic done_d;
   logic tdo_s1, tdo_s2, srst_s1, srst_s2; // pin synchronisers
   logic slot_end; // falling tck: slot over, next bits go out

   assign tap.tck = tck_q;
   assign tap.tms = tms_q;
   assign tap.tdi = tdi_q;
   assign tap.srst_oe = i_sys_reset;
   assign o_sys_reset_seen = !srst_s2;
   assign o_busy = (st_q != H_IDLE);
   assign o_rdata = rx_q;
   assign slot_end = tck_q && (div_q == 4'(jtag_tap_pkg::TCK_HALF_CYC - 1));

   // two flip-flops on pins that come from the far end
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         tdo_s1 <= 1'b1;
         tdo_s2 <= 1'b1;
         srst_s1 <= 1'b1;
         srst_s2 <= 1'b1;
      end else begin
         tdo_s1 <= tap.tdo_pin;
         tdo_s2 <= tdo_s1;
         srst_s1 <= tap.srst_n;
         srst_s2 <= srst_s1;
      end
   end

   // tck runs only during a command, so the port sees no stray edges
   always_comb begin
      st_d = st_q;
      div_d = div_q;
      tck_d = tck_q;
      tms_d = tms_q;
      tdi_d = tdi_q;
      cnt_d = cnt_q;
      seq_d = seq_q;
      seq_len_d = seq_len_q;
      rst_only_d = rst_only_q;
      len_d = len_q;
      tx_d = tx_q;
      rx_d = rx_q;
      done_d = 1'b0;
      if (st_q == H_IDLE) begin
         div_d = '0;
         tck_d = 1'b0;
         tms_d = 1'b0;
         if (i_start) begin
            st_d = H_PRE;
            cnt_d = '0;
            rst_only_d = i_reset_tap;
            len_d = i_len;
            tx_d = i_data;
            rx_d = '0;
            if (i_reset_tap) begin
               seq_d = jtag_tap_pkg::SEQ_RESET;
               seq_len_d = jtag_tap_pkg::LEN_RESET;
            end else if (i_is_ir) begin
               seq_d = jtag_tap_pkg::SEQ_TO_SHIFT_IR;
               seq_len_d = jtag_tap_pkg::LEN_TO_IR;
            end else begin
               seq_d = jtag_tap_pkg::SEQ_TO_SHIFT_DR;
               seq_len_d = jtag_tap_pkg::LEN_TO_DR;
            end
            tms_d = seq_d[0]; // first navigation bit goes out with the first slot
         end
      end else if (div_q == 4'(jtag_tap_pkg::TCK_HALF_CYC - 1)) begin
         div_d = '0;
         tck_d = !tck_q;
      end else begin
         div_d = div_q + 4'h1;
      end
      // at the end of a slot pick the next tms and tdi
      if (st_q != H_IDLE && slot_end) begin
         case (st_q)
            H_PRE: begin
               if (cnt_q == 6'(seq_len_q) - 6'h01) begin
                  cnt_d = '0;
                  st_d = rst_only_q ? H_IDLE : H_SHIFT;
                  done_d = rst_only_q;
                  tms_d = (len_q == 6'h01);
                  tdi_d = tx_q[0];
               end else begin
                  cnt_d = cnt_q + 6'h01;
                  tms_d = seq_q[cnt_q[2:0] + 3'h1];
               end
            end
            H_SHIFT: begin
               rx_d[cnt_q[4:0]] = tdo_s2;
               if (cnt_q == len_q - 6'h01) begin
                  cnt_d = '0;
                  st_d = H_POST;
                  tms_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 6'h01;
                  tms_d = (cnt_q == len_q - 6'h02);
                  tdi_d = tx_q[cnt_q[4:0] + 5'h01];
               end
            end
            H_POST: begin
               if (cnt_q == 6'h01) begin
                  st_d = H_IDLE;
                  done_d = 1'b1;
               end else begin
                  cnt_d = 6'h01;
                  tms_d = 1'b0;
               end
            end
            default: st_d = H_IDLE;
         endcase
      end
   end

   // register host state
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= H_IDLE;
         div_q <= '0;
         tck_q <= 1'b0;
         tms_q <= 1'b1;
         tdi_q <= 1'b1;
         cnt_q <= '0;
         seq_q <= '0;
         seq_len_q <= '0;
         rst_only_q <= 1'b0;
         len_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         o_done <= 1'b0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         tck_q <= tck_d;
         tms_q <= tms_d;
         tdi_q <= tdi_d;
         cnt_q <= cnt_d;
         seq_q <= seq_d;
         seq_len_q <= seq_len_d;
         rst_only_q <= rst_only_d;
         len_q <= len_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         o_done <= done_d;
      end
   end
endmodule // jtag_tap_host

// ---- test/jtag_tap_props.sv ----
// wire-level checks on the pins between the port and its controller
`timescale 1ns/10ps
module jtag_tap_props (
   // system clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // interface signals
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic pullup_en,
   input wire logic srst_oe,
   input wire logic srst_ext_oe,
   input wire logic tdo_pin,
   input wire logic srst_n
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   logic tck_q; // link clock one cycle late, finds rising edges
   logic [2:0] ones_q; // rising edges in a row with tms high, saturates at 5
   logic [2:0] ones_d;
   // count tms-high rising edges; a low one starts over
   always_comb begin
      ones_d = ones_q;
      if (tck && !tck_q) begin
         ones_d = !tms ? 3'h0 : ((ones_q == 3'h5) ? ones_q : ones_q + 3'h1);
      end
   end
   // register helpers only
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         tck_q <= 1'b0;
         ones_q <= 3'h0;
      end else begin
         tck_q <= tck;
         ones_q <= ones_d;
      end
   end
   tck_high_a: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
      else $error("tck high phase not four cycles");
   tck_low_a: assert property ($fell(tck) |-> !tck [*4])
      else $error("tck low phase too short");
   tms_setup_a: assert property ($changed(tms) |-> !tck)
      else $error("tms moved while tck high");
   tdi_setup_a: assert property ($changed(tdi) |-> !tck)
      else $error("tdi moved while tck high");
   tdo_hold_a: assert property (tck && $past(tck, 2) |-> $stable(tdo))
      else $error("tdo moved during tck high");
   shift_exit_a: assert property (tdo_oe && tms && tck && !tck_q |-> ##[1:16] !tdo_oe)
      else $error("tdo still driven after leaving shift");
   five_ones_a: assert property (ones_q == 3'h5 |-> !tdo_oe)
      else $error("tdo driven after five tms highs");
   gpio_quiet_a: assert property (!pullup_en |-> !tdo_oe)
      else $error("tdo driven while port disabled");
   tdo_oe_edge_a: assert property ($changed(tdo_oe) |-> !tck)
      else $error("tdo enable moved while tck high");
   srst_wired_a: assert property (srst_oe || srst_ext_oe |-> !srst_n)
      else $error("reset line not pulled low");
endmodule // jtag_tap_props

// ---- test/tb_jtag_tap_controller.sv ----
// self-checking bench joining the port and its controller end to end
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_jtag_tap_controller;
   // stimulus and observed values
   logic clk_sys, nrst, fuse, dis, dbg, start, rst_tap, is_ir, sys_rst;
   logic busy, done, seen, run_idle, gpio;
   logic [5:0] len;
   logic [31:0] data, rdata, rd;
   logic [7:0] bscan_cap = 8'h5a, iscan_cap = 8'h96, brk_cap = 8'h3c;
   logic [15:0] prog_cap = 16'hc3a6;
   logic [7:0] bscan_q, iscan_q, brk_q;
   logic [15:0] prog_q;
   logic [3:0] instr;
   int n_fail, compares;
   // sample first so the closing bscan_q check can catch a wrong update
   localparam logic [3:0] CODES [7] = '{jtag_tap_pkg::INS_SAMPLE, jtag_tap_pkg::INS_EXTEST,
      jtag_tap_pkg::INS_IDCODE, jtag_tap_pkg::INS_PROG, jtag_tap_pkg::INS_DBG_ISCAN,
      jtag_tap_pkg::INS_DBG_BRK, jtag_tap_pkg::INS_BYPASS};
   localparam int LENS [7] = '{8, 8, 32, 16, 8, 8, 1};
   jtag_tap_if tap_bus();
   jtag_tap_device jtag_tap_device_i (.i_clk_sys(clk_sys), .i_nrst(nrst),
      .i_port_enable_fuse(fuse), .i_software_port_disable_bit(dis), .i_debug_enable_fuse(dbg),
      .i_bscan_capture(bscan_cap), .i_prog_capture(prog_cap), .i_iscan_capture(iscan_cap),
      .i_brk_capture(brk_cap), .o_bscan_q(bscan_q), .o_prog_q(prog_q), .o_iscan_q(iscan_q),
      .o_brk_q(brk_q), .o_instruction(instr), .o_run_idle(run_idle), .o_gpio_mode(gpio),
      .tap(tap_bus));
   jtag_tap_host jtag_tap_host_i (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_start(start),
      .i_reset_tap(rst_tap), .i_is_ir(is_ir), .i_len(len), .i_data(data), .o_busy(busy),
      .o_done(done), .o_rdata(rdata), .i_sys_reset(sys_rst), .o_sys_reset_seen(seen),
      .tap(tap_bus));
   jtag_tap_props jtag_tap_props_i (.i_clk_sys(clk_sys), .i_nrst(nrst), .tck(tap_bus.tck),
      .tms(tap_bus.tms), .tdi(tap_bus.tdi), .tdo(tap_bus.tdo), .tdo_oe(tap_bus.tdo_oe),
      .pullup_en(tap_bus.pullup_en), .srst_oe(tap_bus.srst_oe),
      .srst_ext_oe(tap_bus.srst_ext_oe), .tdo_pin(tap_bus.tdo_pin), .srst_n(tap_bus.srst_n));
   // distinct data per instruction so a wrong update target shows
   function automatic logic [31:0] pat(input logic [3:0] c);
      return 32'h9e37_79b9 ^ {8{c}};
   endfunction
   // one host command, entered 2 ns after an edge; waits for done, bounded
   task automatic scan(input logic r, input logic ir, input logic [5:0] n,
      input logic [31:0] d);
      rst_tap = r;
      is_ir = ir;
      len = n;
      data = d;
      start = 1'b1;
      @(posedge clk_sys);
      #2;
      start = 1'b0;
      `CHK(busy, 1'b1)
      for (int k = 0; k < 4000 && done !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
      if (done !== 1'b1) n_fail++;
      rd = rdata;
      #1;
   endtask
   // every instruction: ir capture, latch, then its data register
   task automatic t_paths();
      logic [31:0] caps [7];
      caps = '{32'(bscan_cap), 32'(bscan_cap), jtag_tap_pkg::ID_VALUE, 32'(prog_cap),
         32'(iscan_cap), 32'(brk_cap), 32'h0};
      for (int k = 0; k < 7; k++) begin
         scan(1'b0, 1'b1, 6'h4, {28'h0, CODES[k]});
         `CHK(rd, 32'h1)
         `CHK(instr, CODES[k])
         `CHK(run_idle, 1'b1)
         scan(1'b0, 1'b0, 6'(LENS[k]), pat(CODES[k]));
         `CHK(rd, caps[k])
      end
      `CHK(bscan_q, 8'(pat(jtag_tap_pkg::INS_EXTEST)))
      `CHK(prog_q, 16'(pat(jtag_tap_pkg::INS_PROG)))
      `CHK(iscan_q, 8'(pat(jtag_tap_pkg::INS_DBG_ISCAN)))
      `CHK(brk_q, 8'(pat(jtag_tap_pkg::INS_DBG_BRK)))
   endtask
   // debug chain without its fuse falls back to the one-bit bypass
   task automatic t_dbg_off();
      dbg = 1'b0;
      scan(1'b0, 1'b1, 6'h4, {28'h0, jtag_tap_pkg::INS_DBG_ISCAN});
      scan(1'b0, 1'b0, 6'h2, 32'h3);
      `CHK(rd, 32'h2)
      `CHK(iscan_q, 8'(pat(jtag_tap_pkg::INS_DBG_ISCAN)))
      dbg = 1'b1;
   endtask
   // five tms highs restore the reset instruction
   task automatic t_tms_reset();
      scan(1'b0, 1'b1, 6'h4, {28'h0, jtag_tap_pkg::INS_EXTEST});
      scan(1'b1, 1'b0, 6'h0, 32'h0);
      `CHK(instr, jtag_tap_pkg::IR_RESET)
   endtask
   // disable bit held in reset, then fuse alone checked for gpio mode
   task automatic t_port_off();
      scan(1'b0, 1'b1, 6'h4, {28'h0, jtag_tap_pkg::INS_PROG});
      dis = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2;
      `CHK(gpio, 1'b1)
      `CHK(tap_bus.pullup_en, 1'b0)
      `CHK(instr, jtag_tap_pkg::IR_RESET)
      dis = 1'b0;
      #1;
      `CHK(tap_bus.pullup_en, 1'b1)
      fuse = 1'b0;
      #1;
      `CHK(gpio, 1'b1)
      fuse = 1'b1;
   endtask
   // outside and host reset sources on the shared line
   task automatic t_sys_reset();
      tap_bus.srst_ext_oe = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2;
      `CHK(seen, 1'b1)
      tap_bus.srst_ext_oe = 1'b0;
      repeat (4) @(posedge clk_sys);
      #2;
      `CHK(seen, 1'b0)
      sys_rst = 1'b1;
      #1;
      `CHK(tap_bus.srst_n, 1'b0)
      repeat (4) @(posedge clk_sys);
      #2;
      `CHK(seen, 1'b1)
      sys_rst = 1'b0;
   endtask
   // verdict and stop
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // system clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // watchdog: full run is well under 200 us
   initial begin
      #1ms;
      n_fail++;
      end_of_test();
   end
   // main sequence
   initial begin
      {nrst, dis, start, rst_tap, is_ir, sys_rst, len, data} = '0;
      {fuse, dbg} = 2'b11;
      tap_bus.srst_ext_oe = 1'b0;
      n_fail = 0;
      compares = 0;
      repeat (4) @(posedge clk_sys);
      #2;
      nrst = 1'b1;
      @(posedge clk_sys);
      #2;
      `CHK(instr, jtag_tap_pkg::IR_RESET)
      `CHK(run_idle, 1'b0)
      scan(1'b1, 1'b0, 6'h0, 32'h0);
      t_paths();
      t_dbg_off();
      t_tms_reset();
      t_port_off();
      t_sys_reset();
      end_of_test();
   end
endmodule // tb_jtag_tap_controller
